// File: pkg/pio_defines.svh
// Purpose: register offsets and field constants for the parallel port block
// Assumes: APB byte addresses, one register per aligned 32-bit word
// Notes:   included by the package and the design files
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define PIO_IDX_DATA_A     8'h00
`define PIO_IDX_DATA_B     8'h01
`define PIO_IDX_DATA_C     8'h02
`define PIO_IDX_DIR_A      8'h04
`define PIO_IDX_DIR_B      8'h05
`define PIO_IDX_DIR_C      8'h06
`define PIO_IDX_PULL_A     8'h0D
`define PIO_IDX_PULL_C     8'h0E
`define PIO_IDX_ALT_CTRL   8'h10
`define PIO_ADDR_W         12
`define PIO_BYTE_ADDR(i)   {2'h0, (i), 2'h0}

// ----------------------------------------
// Widths, masks and reset values
// ----------------------------------------
`define PIO_AB_W           8
`define PIO_C_W            7
`define PIO_CH_W           5
`define PIO_DIR_RST        8'h00
`define PIO_PULL_RST       8'h00
`define PIO_ALT_RST        16'h0000
`define PIO_CAN_EN_BIT     15
`define PIO_CHSEL_LSB      8
`define PIO_CH_NONE        5'h1F
`define PIO_CAN_TX_BIT     0
`define PIO_CAN_RX_BIT     1

`endif

// File: pkg/pio_pkg.sv
// Purpose: shared types of the parallel port block
// Assumes: constants come from pio_defines.svh
// Notes:   the state struct holds the reset registers; data latches sit outside it
`include "pio_defines.svh"

package pio_pkg;

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   typedef struct packed {
      logic [7:0]  dataA;
      logic [7:0]  dataB;
      logic [6:0]  dataC;
      logic [7:0]  dirA;
      logic [7:0]  dirB;
      logic [6:0]  dirC;
      logic [7:0]  pullA;
      logic [6:0]  pullC;
      logic [7:0]  keyEn;
      logic [4:0]  chSel;
      logic        can_pin_enable;
   } pio_state_t;

   typedef enum logic [0:0] {
      PIO_IDLE   = 1'b0,
      PIO_ACCESS = 1'b1
   } pio_phase_t;

endpackage

// File: design/pio_sync.sv
// Purpose: two-stage synchroniser for a vector of pin levels
// Assumes: one clock, asynchronous active-low reset
// Notes:   the first stage feeds only the second
`timescale 1ns/1ps
`include "pio_defines.svh"

module pio_sync
   import pio_pkg::*;
#(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] async,
   output logic      [W-1:0] synced
);

   // ----------------------------------------
   // Two flops per bit
   // ----------------------------------------
   logic [W-1:0] meta_r;

   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : gBit
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               meta_r[g] <= 1'b0;
               synced[g] <= 1'b0;
            end else begin
               meta_r[g] <= async[g];
               synced[g] <= meta_r[g];
            end
         end
      end
   endgenerate

endmodule

// File: design/pio_ports.sv
// Purpose: general purpose I/O for ports A, B and C behind an APB slave
// Assumes: 250 MHz clk, pins sampled through two flops before use
// Notes:   data latches have no reset; direction and pullups clear on reset
//
// Notes on behaviour
// - Ports A and B each have eight software read/write data latches.
// - Reset leaves the data latches untouched.
// - A direction bit of 1 enables the pin output buffer, 0 disables it.
// - Reset clears every direction bit so all pins start as inputs.
// - A data read returns the latch for bits whose direction is output.
// - A data read returns the synchronised pin level for input bits.
// - Data writes always reach the latch, whatever the direction.
// - A-port and C-port pullups are on only when enabled and input.
// - A pullup-enable bit of 1 connects the pullup, 0 disconnects it.
// - Each key interrupt enable turns its A pin into a key input.
// - A converter-selected B pin is analog input, port logic ignored; here only its output enable is forced off, data reads are unchanged.
// - Port C is a seven-bit port with data, direction and pullups.
// - CAN enable hands C pin 1 to receive and C pin 0 to transmit.
// - Bit 7 of the C direction register is absent and reads zero.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "pio_defines.svh"

module pio_ports
   import pio_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  portAIn,
   output logic      [7:0]  portAOut,
   output logic      [7:0]  portAOe,
   output logic      [7:0]  portAPullup,
   input  wire logic [7:0]  portBIn,
   output logic      [7:0]  portBOut,
   output logic      [7:0]  portBOe,
   output logic      [7:0]  analogChannelInputs,
   input  wire logic [6:0]  portCIn,
   output logic      [6:0]  portCOut,
   output logic      [6:0]  portCOe,
   output logic      [6:0]  portCPullup,
   output logic      [7:0]  keyIrqInputs,
   output logic      [7:0]  keyIrqPinEnables,
   output logic             canReceivePin,
   input  wire logic        canTransmitPin,
   output logic             canPinEnable
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [7:0] syncA;
   logic [7:0] syncB;
   logic [6:0] syncC;

   pio_sync #(.W(8)) uSyncA (
      .clk    (clk),
      .rstn   (rstn),
      .async  (portAIn),
      .synced (syncA)
   );
   pio_sync #(.W(8)) uSyncB (
      .clk    (clk),
      .rstn   (rstn),
      .async  (portBIn),
      .synced (syncB)
   );
   pio_sync #(.W(7)) uSyncC (
      .clk    (clk),
      .rstn   (rstn),
      .async  (portCIn),
      .synced (syncC)
   );

   // ----------------------------------------
   // State
   // ----------------------------------------
   // Latches live outside the reset struct so reset cannot touch them
   pio_state_t st_r;
   pio_state_t st_nxt;
   logic [7:0] latA_r;
   logic [7:0] latB_r;
   logic [6:0] latC_r;
   logic [7:0] latA_nxt;
   logic [7:0] latB_nxt;
   logic [6:0] latC_nxt;
   logic [31:0] rdData;
   logic        wrEn;
   logic        rdHit;
   logic [7:0]  byteIdx;
   logic [7:0]  anaMask;
   logic [7:0]  wb;
   logic        canOn;

   assign byteIdx = paddr[9:2];
   assign wrEn    = psel && penable && pwrite && pstrb[0];
   assign wb      = pwdata[7:0];
   assign canOn   = st_r.can_pin_enable;

   // Analog select of one B pin forces off its output enable; reads still see latch or pin
   always_comb begin
      anaMask = 8'h00;
      if (st_r.chSel < 5'h08) begin
         anaMask[st_r.chSel[2:0]] = 1'b1;
      end
   end

   // ----------------------------------------
   // Next state and write decode
   // ----------------------------------------
   always_comb begin
      st_nxt   = st_r;
      latA_nxt = latA_r;
      latB_nxt = latB_r;
      latC_nxt = latC_r;
      if (wrEn && paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0) begin
         case (byteIdx)
            `PIO_IDX_DATA_A: latA_nxt = wb;
            `PIO_IDX_DATA_B: latB_nxt = wb;
            `PIO_IDX_DATA_C: latC_nxt = wb[6:0];
            `PIO_IDX_DIR_A:  st_nxt.dirA = wb;
            `PIO_IDX_DIR_B:  st_nxt.dirB = wb;
            `PIO_IDX_DIR_C:  st_nxt.dirC = wb[6:0];
            `PIO_IDX_PULL_A: st_nxt.pullA = wb;
            `PIO_IDX_PULL_C: st_nxt.pullC = wb[6:0];
            `PIO_IDX_ALT_CTRL: begin
               st_nxt.keyEn = wb;
               if (pstrb[1]) begin
                  st_nxt.chSel = pwdata[`PIO_CHSEL_LSB +: `PIO_CH_W];
                  st_nxt.can_pin_enable = pwdata[`PIO_CAN_EN_BIT];
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r       <= '0;
         st_r.chSel <= `PIO_CH_NONE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // No reset on purpose: contents survive reset
   always_ff @(posedge clk) begin
      latA_r <= latA_nxt;
      latB_r <= latB_nxt;
      latC_r <= latC_nxt;
   end

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   always_comb begin
      portAOut    = latA_r;
      portAOe     = st_r.dirA;
      portAPullup = st_r.pullA & ~st_r.dirA;
      portBOut    = latB_r;
      portBOe     = st_r.dirB & ~anaMask;
      portCOut    = latC_r;
      portCOe     = st_r.dirC;
      portCPullup = st_r.pullC & ~st_r.dirC;
      if (canOn) begin
         portCOut[`PIO_CAN_TX_BIT]    = canTransmitPin;
         portCOe[`PIO_CAN_TX_BIT]     = 1'b1;
         portCOe[`PIO_CAN_RX_BIT]     = 1'b0;
         portCPullup[`PIO_CAN_TX_BIT] = 1'b0;
         portCPullup[`PIO_CAN_RX_BIT] = 1'b0;
      end
   end

   assign keyIrqPinEnables    = st_r.keyEn;
   assign keyIrqInputs        = syncA & st_r.keyEn;
   assign analogChannelInputs = anaMask;
   assign canReceivePin       = canOn ? syncC[`PIO_CAN_RX_BIT] : 1'b1;
   assign canPinEnable        = canOn;

   // ----------------------------------------
   // APB read path
   // ----------------------------------------
   always_comb begin
      rdData = 32'h0000_0000;
      rdHit  = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
      case (byteIdx)
         `PIO_IDX_DATA_A:
            rdData[7:0] = (st_r.dirA & latA_r)
                        | (~st_r.dirA & syncA);
         `PIO_IDX_DATA_B:
            rdData[7:0] = (st_r.dirB & latB_r)
                        | (~st_r.dirB & syncB);
         `PIO_IDX_DATA_C:
            rdData[6:0] = (st_r.dirC & latC_r)
                        | (~st_r.dirC & syncC);
         `PIO_IDX_DIR_A:  rdData[7:0] = st_r.dirA;
         `PIO_IDX_DIR_B:  rdData[7:0] = st_r.dirB;
         `PIO_IDX_DIR_C:  rdData[6:0] = st_r.dirC;
         `PIO_IDX_PULL_A: rdData[7:0] = st_r.pullA;
         `PIO_IDX_PULL_C: rdData[6:0] = st_r.pullC;
         `PIO_IDX_ALT_CTRL: begin
            rdData[7:0]             = st_r.keyEn;
            rdData[`PIO_CHSEL_LSB +: `PIO_CH_W] = st_r.chSel;
            rdData[`PIO_CAN_EN_BIT] = st_r.can_pin_enable;
         end
         default: rdHit = 1'b0;
      endcase
      if (!rdHit) begin
         rdData = 32'h0000_0000;
      end
   end

   // Zero wait states keep the bus simple; errors flag unmapped words
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !rdHit;
   assign prdata  = (psel && penable && !pwrite) ? rdData : 32'h0000_0000;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_dir_reset_clear: assert property (@(posedge clk)
      $rose(rstn) |-> (portAOe == 8'h00 && portBOe == 8'h00
                       && portCOe == 7'h00))
      else $error("direction not clear after reset");

   a_pullup_out_off: assert property (@(posedge clk) disable iff (!rstn)
      (portAPullup & st_r.dirA) == 8'h00)
      else $error("port A pullup on while output");

   a_pullup_c_off: assert property (@(posedge clk) disable iff (!rstn)
      (portCPullup & st_r.dirC) == 7'h00)
      else $error("port C pullup on while output");

   a_write_latch: assert property (@(posedge clk) disable iff (!rstn)
      (wrEn && paddr == 12'h000) |=> portAOut == $past(pwdata[7:0]))
      else $error("port A write lost");

   a_dir_drive: assert property (@(posedge clk) disable iff (!rstn)
      (wrEn && paddr == 12'h010) |=> portAOe == $past(pwdata[7:0]))
      else $error("port A direction not applied");

   a_read_output: assert property (@(posedge clk) disable iff (!rstn)
      (psel && penable && !pwrite && paddr == 12'h004
       && st_r.dirB == 8'hFF) |-> prdata[7:0] == latB_r)
      else $error("port B output read wrong");

   a_read_input: assert property (@(posedge clk) disable iff (!rstn)
      (psel && penable && !pwrite && paddr == 12'h000
       && st_r.dirA == 8'h00) |-> prdata[7:0] == syncA)
      else $error("port A input read wrong");

   a_dirc_top_zero: assert property (@(posedge clk) disable iff (!rstn)
      (psel && penable && !pwrite && paddr == 12'h018)
      |-> prdata[7] == 1'b0)
      else $error("direction C bit 7 not zero");

   a_analog_off: assert property (@(posedge clk) disable iff (!rstn)
      (portBOe & anaMask) == 8'h00)
      else $error("analog pin driven");

   // A write must land at the very edge that ends its access phase
   a_single_cycle: assert property (@(posedge clk) disable iff (!rstn)
      (psel && penable && pwrite && pstrb[0] && paddr == 12'h014)
      |-> pready ##1 (st_r.dirB == $past(pwdata[7:0])))
      else $error("access took extra cycles");

endmodule

// File: sim/pio_pin_model.sv
// Purpose: pin side of ports A, B and C
// Assumes: outside drivers are weaker than the pullups
// Notes:   pin shows latch when driven, else pullup, else outside level
`timescale 1ns/1ps
module pio_pin_model (
   input  wire logic [7:0] aOut,
   input  wire logic [7:0] aOe,
   input  wire logic [7:0] aPull,
   input  wire logic [7:0] extA,
   input  wire logic [7:0] bOut,
   input  wire logic [7:0] bOe,
   input  wire logic [7:0] extB,
   input  wire logic [6:0] cOut,
   input  wire logic [6:0] cOe,
   input  wire logic [6:0] cPull,
   input  wire logic [6:0] extC,
   output logic      [7:0] aPin,
   output logic      [7:0] bPin,
   output logic      [6:0] cPin
);
   // Port B has no pullups, so an undriven B pin follows the outside
   assign aPin = (aOe & aOut) | (~aOe & (aPull | extA));
   assign bPin = (bOe & bOut) | (~bOe & extB);
   assign cPin = (cOe & cOut) | (~cOe & (cPull | extC));
endmodule

// File: sim/pio_ports_tb.sv
// Purpose: self-checking bench for the parallel port block
// Assumes: zero-wait APB slave, pins synchronised in two flops
// Notes:   reference model keeps register images in an int array
`timescale 1ns/1ps
`include "pio_defines.svh"
module pio_ports_tb
   import pio_pkg::*;
;
   logic        clk, rstn, psel, penable, pwrite, can_transmit_pin, pready, lastErr;
   logic        can_receive_pin, canEnO, slvErr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [7:0]  aOut, aOe, aPull, aIn, bOut, bOe, bIn, anSel, keyIn, keyEn;
   logic [7:0]  extA, extB;
   logic [6:0]  cOut, cOe, cPull, cIn, extC;
   logic [31:0] seed = 32'h56;
   int          errTotal, samplesChecked, i, k, v;
   int          m [9];
   logic [11:0] ra [9] = '{`PIO_BYTE_ADDR(`PIO_IDX_DATA_A),
      `PIO_BYTE_ADDR(`PIO_IDX_DATA_B), `PIO_BYTE_ADDR(`PIO_IDX_DATA_C),
      `PIO_BYTE_ADDR(`PIO_IDX_DIR_A), `PIO_BYTE_ADDR(`PIO_IDX_DIR_B),
      `PIO_BYTE_ADDR(`PIO_IDX_DIR_C), `PIO_BYTE_ADDR(`PIO_IDX_PULL_A),
      `PIO_BYTE_ADDR(`PIO_IDX_PULL_C), `PIO_BYTE_ADDR(`PIO_IDX_ALT_CTRL)};

   pio_ports DUT (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
      .prdata(prdata), .pready(pready), .pslverr(lastErr), .portAIn(aIn),
      .portAOut(aOut), .portAOe(aOe), .portAPullup(aPull), .portBIn(bIn),
      .portBOut(bOut), .portBOe(bOe), .analogChannelInputs(anSel),
      .portCIn(cIn), .portCOut(cOut), .portCOe(cOe), .portCPullup(cPull),
      .keyIrqInputs(keyIn), .keyIrqPinEnables(keyEn),
      .canReceivePin(can_receive_pin), .canTransmitPin(can_transmit_pin),
      .canPinEnable(canEnO));
   pio_pin_model pins (.aOut(aOut), .aOe(aOe), .aPull(aPull), .extA(extA),
      .bOut(bOut), .bOe(bOe), .extB(extB), .cOut(cOut), .cOe(cOe),
      .cPull(cPull), .extC(extC), .aPin(aIn), .bPin(bIn), .cPin(cIn));

   // ----------------------------------------
   // Model, bus tasks and checks
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic int ex(int n);
      case (n)
         0: return ((m[3] & m[0]) | (~m[3] & (m[6] | extA))) & 32'hFF;
         1: return ((m[4] & m[1]) | (~m[4] & extB)) & 32'hFF;
         2: return ((m[5] & m[2]) | (~m[5] & (m[7] | extC))) & 32'h7F;
         5, 7: return m[n] & 32'h7F;
         8: return m[n] & 32'h9FFF;
         default: return m[n] & 32'hFF;
      endcase
   endfunction

   task automatic summarize();
      $display("checks %0d errors %0d", samplesChecked, errTotal);
      if (errTotal == 0 && samplesChecked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samplesChecked++;
      if (s !== e) begin
         errTotal++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic apb(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         errTotal++;
         summarize();
      end
      chk(n, 1);
      r = prdata;
      slvErr = lastErr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input int n, input logic [31:0] e);
      apb(ra[n], 1'b0, 32'h0);
      chk(r, e);
      chk(slvErr, 1'b0);
   endtask

   // ----------------------------------------
   // Clock, timeout and main sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      #100000;
      errTotal++;
      summarize();
   end

   initial begin
      {rstn, psel, penable, pwrite, can_transmit_pin, paddr, pwdata} = '0;
      {extA, extB, extC} = '0;
      errTotal = 0;
      samplesChecked = 0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      m = '{default: 0};
      m[8] = 32'h1F00;
      for (i = 3; i < 9; i++) rd(i, ex(i));
      chk(aOe, 32'h0);
      for (k = 0; k < 8; k++) begin
         for (i = 0; i < 8; i++) m[i] = rnd();
         m[8] = 32'h1F00 | (rnd() & 32'hFF);
         {extA, extB, extC} <= 23'(rnd());
         // Data loaded before directions, so no output glitch
         for (i = 0; i < 9; i++) apb(ra[i], 1'b1, m[i]);
         repeat (3) @(posedge clk);
         for (i = 0; i < 9; i++) rd(i, ex(i));
         chk(aOut, m[0] & 32'hFF);
         chk(bOut, m[1] & 32'hFF);
         chk(cOut, m[2] & 32'h7F);
         chk(aOe, m[3] & 32'hFF);
         chk(cOe, m[5] & 32'h7F);
         chk(aPull, m[6] & ~m[3] & 32'hFF);
         chk(cPull, m[7] & ~m[5] & 32'h7F);
         chk(keyIn, ex(0) & m[8] & 32'hFF);
         chk(keyEn, m[8] & 32'hFF);
      end
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      for (i = 3; i < 8; i++) m[i] = 0;
      m[8] = 32'h1F00;
      chk(aOut, m[0] & 32'hFF);
      chk(cOut, m[2] & 32'h7F);
      repeat (3) @(posedge clk);
      for (i = 0; i < 9; i++) rd(i, ex(i));
      apb(ra[4], 1'b1, 32'hFF);
      m[4] = 32'hFF;
      rd(1, ex(1));
      for (k = 0; k < 9; k++) begin
         apb(ra[8], 1'b1, k << 8);
         #1;
         v = (k < 8) ? (1 << k) : 0;
         chk(anSel, v);
         chk(bOe, 32'hFF & ~v);
      end
      apb(ra[7], 1'b1, 32'h7F);
      apb(ra[5], 1'b1, 32'h02);
      can_transmit_pin <= seed[0];
      apb(ra[8], 1'b1, 32'h9F00);
      repeat (3) @(posedge clk);
      #1;
      chk(cOe[1:0], 2'b01);
      chk(cOut[0], can_transmit_pin);
      chk(can_receive_pin, extC[1]);
      chk({canEnO, cPull[1:0]}, 3'b100);
      apb(ra[8], 1'b1, 32'h1F00);
      repeat (3) @(posedge clk);
      #1;
      chk({can_receive_pin, cOe[1:0]}, 3'b110);
      apb(12'h00C, 1'b0, 32'h0);
      chk(slvErr, 1'b1);
      chk(r, 32'h0);
      summarize();
   end
endmodule
